// >>> hdl/expander_pkg.sv
// Shared constants and types for the serial port expander
package expander_pkg;

  // Port geometry
  localparam int PIN_W  = 16;
  localparam int PORT_W = 8;
  localparam int CNT_W  = 5;

  // Register reset values: all open-drain, all released
  localparam logic [PIN_W-1:0] DIR_TYPE_RST  = 16'h0000;
  localparam logic [PIN_W-1:0] OUT_LEVEL_RST = 16'hffff;

  // Direction/type and output-level encodings
  localparam logic TYPE_OPEN_DRAIN = 1'b0;
  localparam logic TYPE_CMOS       = 1'b1;
  localparam logic LEVEL_LOW       = 1'b0;
  localparam logic LEVEL_RELEASE   = 1'b1;

  // Frame geometry
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
  localparam int               FIRST_BIT  = 0;

  // Serial out level while idle or in reset
  localparam logic DOUT_IDLE = 1'b1;

  // Timing: system clock and select low hold time
  localparam int CLK_PERIOD_PS          = 5000;
  localparam int SELECT_LOW_HOLD_TIME_NS = 200;
  localparam int SELECT_LOW_HOLD_CYC     =
    (SELECT_LOW_HOLD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 8;

  // Communication mode
  typedef enum logic [1:0] {
    MODE_INIT = 2'b00,
    MODE_DATA = 2'b01
  } mode_t;

endpackage

// >>> hdl/link_if.sv
// Carrier between the core and the link-clock shifter
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  import expander_pkg::*;

  logic [PIN_W-1:0] rx_word;
  logic             rise_seen;
  logic             frame_full;
  logic             clr;
  logic [PIN_W-1:0] in_enable;

  modport link (
    output rx_word,
    output rise_seen,
    output frame_full,
    input  clr,
    input  in_enable
  );

  modport core (
    input  rx_word,
    input  rise_seen,
    input  frame_full,
    output clr,
    output in_enable
  );
endinterface
`default_nettype wire

// >>> hdl/link_shifter.sv
// Serial shifter running on the serial clock
`timescale 1ns/1ps
`default_nettype none
module link_shifter
  import expander_pkg::*;
(
  // Link
  input  wire logic             i_sclk,
  input  wire logic             i_nrst,
  input  wire logic             i_cs_n,
  input  wire logic             i_din,
  output logic                  o_dout,
  // Raw pin levels
  input  wire logic [PIN_W-1:0] i_expander_pins,
  // Core side
  link_if.link                  lk
);

  logic                 link_rst;
  logic                 active;
  logic [PIN_W-1:0]     sample;
  logic [CNT_W-1:0]     rise_cnt_ff;
  logic [CNT_W-1:0]     fall_cnt_ff;
  logic [PIN_W-1:0]     rx_ff;
  logic [PIN_W-1:0]     cap_ff;
  logic                 seen_ff;
  logic                 full_ff;
  logic                 first_ff;
  logic                 dout_ff;

  // Clear comes from a core flop, so the reset is glitch free
  assign link_rst = ~i_nrst | lk.clr;
  assign active   = ~i_cs_n;

  // Disabled inputs read high
  assign sample = i_expander_pins | ~lk.in_enable;

  //////////////////////////////////////////////////////////////////////
  // Rising edges: capture serial in and the port samples
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      rise_cnt_ff <= CNT_ZERO;
      seen_ff     <= 1'b0;
      full_ff     <= 1'b0;
    end else if (active && rise_cnt_ff != FRAME_BITS) begin
      rise_cnt_ff <= rise_cnt_ff + CNT_ONE;
      seen_ff     <= 1'b1;
      full_ff     <= (rise_cnt_ff + CNT_ONE) == FRAME_BITS;
    end
  end

  // Pin zero enters first and ends at bit zero
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      rx_ff <= OUT_LEVEL_RST;
    end else if (active && rise_cnt_ff != FRAME_BITS) begin
      rx_ff <= {i_din, rx_ff[PIN_W-1:1]};
    end
  end

  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      cap_ff <= OUT_LEVEL_RST;
    end else if (active && rise_cnt_ff == CNT_ZERO) begin
      cap_ff <= sample;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Falling edges: advance the returned samples
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      fall_cnt_ff <= CNT_ZERO;
      first_ff    <= 1'b0;
      dout_ff     <= DOUT_IDLE;
    end else if (active && fall_cnt_ff != FRAME_BITS) begin
      fall_cnt_ff <= fall_cnt_ff + CNT_ONE;
      first_ff    <= fall_cnt_ff == CNT_ZERO;
      if (fall_cnt_ff != CNT_ZERO) begin
        dout_ff <= cap_ff[fall_cnt_ff[3:0]];
      end
    end
  end

  // First bit is the live pin, unlatched, so it shows pin settling
  assign o_dout = first_ff ? sample[FIRST_BIT] : dout_ff;

  assign lk.rx_word    = rx_ff;
  assign lk.rise_seen  = seen_ff;
  assign lk.frame_full = full_ff;

endmodule
`default_nettype wire

// >>> hdl/serial_port_expander_16bit.sv
// Top of the 16-bit serial port expander: modes, registers, pin drive
`timescale 1ns/1ps
`default_nettype none
module serial_port_expander_16bit
  import expander_pkg::*;
(
  // System
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Serial link
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  input  wire logic             i_din,
  output logic                  o_dout,
  // Expander pins
  input  wire logic [PIN_W-1:0] i_expander_pins,
  output logic      [PIN_W-1:0] o_expander_pins,
  output logic      [PIN_W-1:0] o_expander_pins_oe,
  // Status
  output logic                  o_data_mode
);

  localparam int SYNC_N = 3;
  localparam int S_CS   = 0;
  localparam int S_SEEN = 1;
  localparam int S_FULL = 2;
  localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(SELECT_LOW_HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_ONE = 8'h01;
  localparam logic [SYNC_N-1:0] SYNC_RST = 3'h1;

  link_if lk ();

  logic [SYNC_N-1:0] meta_ff;
  logic [SYNC_N-1:0] sync_ff;
  logic              cs_d_ff;
  logic              cs_rise;
  logic              cs_fall;
  logic [HOLD_W-1:0] low_cnt_ff;
  logic [HOLD_W-1:0] nxt_low_cnt;
  mode_t             mode_ff;
  mode_t             nxt_mode;
  logic [PIN_W-1:0]  dir_type_ff;
  logic [PIN_W-1:0]  out_level_ff;
  logic              clr_ff;
  logic              hold_met;
  logic              load_dir;
  logic              load_level;

  //////////////////////////////////////////////////////////////////////
  // Link-clock shifter
  link_shifter u_link (
    .i_sclk          (i_sclk),
    .i_nrst          (i_nrst),
    .i_cs_n          (i_cs_n),
    .i_din           (i_din),
    .o_dout          (o_dout),
    .i_expander_pins (i_expander_pins),
    .lk              (lk.link)
  );

  // Settings only change between frames, so the shifter sees them static
  assign lk.in_enable = ~dir_type_ff & out_level_ff;
  assign lk.clr       = clr_ff;

  //////////////////////////////////////////////////////////////////////
  // Synchronisers: chip select, edge seen, frame full
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {lk.frame_full, lk.rise_seen, i_cs_n};
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_d_ff <= 1'b1;
    end else begin
      cs_d_ff <= sync_ff[S_CS];
    end
  end

  assign cs_rise = sync_ff[S_CS] & ~cs_d_ff;
  assign cs_fall = ~sync_ff[S_CS] & cs_d_ff;

  //////////////////////////////////////////////////////////////////////
  // Select low time, saturating
  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    if (cs_fall) begin
      nxt_low_cnt = HOLD_ONE;
    end else if (!sync_ff[S_CS] && low_cnt_ff != HOLD_CYC) begin
      nxt_low_cnt = low_cnt_ff + HOLD_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  assign hold_met = low_cnt_ff == HOLD_CYC;

  //////////////////////////////////////////////////////////////////////
  // Mode control; the shifter is idle once select is high
  always_comb begin
    nxt_mode   = mode_ff;
    load_dir   = 1'b0;
    load_level = 1'b0;
    unique case (mode_ff)
      MODE_INIT: begin
        if (cs_rise) begin
          if (!sync_ff[S_SEEN] && hold_met) begin
            nxt_mode = MODE_DATA;
          end else if (sync_ff[S_FULL]) begin
            load_dir = 1'b1;
            nxt_mode = MODE_DATA;
          end
        end
      end
      MODE_DATA: begin
        load_level = cs_rise & sync_ff[S_FULL];
      end
      default: begin
        nxt_mode = MODE_INIT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_ff <= MODE_INIT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  assign o_data_mode = mode_ff == MODE_DATA;

  //////////////////////////////////////////////////////////////////////
  // Registers, loaded only at select rise
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dir_type_ff <= DIR_TYPE_RST;
    end else if (load_dir) begin
      dir_type_ff <= lk.rx_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_level_ff <= OUT_LEVEL_RST;
    end else if (load_level) begin
      out_level_ff <= lk.rx_word;
    end
  end

  // Clear the shifter after the word is taken
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clr_ff <= 1'b0;
    end else begin
      clr_ff <= cs_rise;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin drive, two ports of eight
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_pin
      assign o_expander_pins[gi]    = out_level_ff[gi];
      assign o_expander_pins_oe[gi] =
        (dir_type_ff[gi] == TYPE_CMOS) |
        (out_level_ff[gi] == LEVEL_LOW);
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sim/expander_assertions.sv
// Port-level checks for the serial port expander
`timescale 1ns/1ps
`default_nettype none
module expander_assertions
  import expander_pkg::*;
(
  // System and link
  input wire logic             i_clk,
  input wire logic             i_nrst,
  input wire logic             i_cs_n,
  input wire logic             o_dout,
  // Pins and status
  input wire logic [PIN_W-1:0] o_expander_pins,
  input wire logic [PIN_W-1:0] o_expander_pins_oe,
  input wire logic             o_data_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  //////////////////////////////////////////
  low_drives_a: assert property ((~o_expander_pins & ~o_expander_pins_oe) == 16'h0000)
    else $error("low level pin not driven");
  pins_frozen_a: assert property (!i_cs_n && !$past(i_cs_n) |-> $stable(o_expander_pins))
    else $error("pins changed inside a frame");
  mode_sticky_a: assert property (o_data_mode |=> o_data_mode)
    else $error("data mode left");
  mode_entry_a: assert property ($rose(o_data_mode) |-> i_cs_n && $stable(o_expander_pins))
    else $error("mode entry out of place");
  dout_idle_a: assert property (i_cs_n [*8] |-> o_dout)
    else $error("serial out not idle high");
  init_released_a: assert property (!o_data_mode |-> o_expander_pins == 16'hffff
    && o_expander_pins_oe == 16'h0000)
    else $error("pins not released before setup");
  late_update_a: assert property (!$stable(o_expander_pins_oe) |-> i_cs_n && $past(i_cs_n))
    else $error("drive changed before select rise");
  select_start_a: assert property ($fell(i_cs_n) |-> o_dout)
    else $error("serial out busy before clocking");
endmodule
bind serial_port_expander_16bit expander_assertions expander_assertions_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .o_dout(o_dout),
  .o_expander_pins(o_expander_pins), .o_expander_pins_oe(o_expander_pins_oe),
  .o_data_mode(o_data_mode));
`default_nettype wire

// >>> sim/link_master.sv
// Behavioural link master on the serial side
`timescale 1ns/1ps
`default_nettype none
module link_master (
  // Serial link
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din,
  input  wire logic i_dout
);
  localparam int HALF = 3;
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  //////////////////////////////////////////
  // Clock stands high between frames; released din shows the inverse
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'hffff;
    o_cs_n = 1'b0;
    #110;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b0;
      o_din  = tx[i];
      #HALF;
      rx[i]  = i_dout;
      o_sclk = 1'b1;
      #HALF;
    end
    o_cs_n = 1'b1;
    o_din  = ~o_din;
    #60;
  endtask
  task automatic hold_low();
    o_cs_n = 1'b0;
    #250;
    o_cs_n = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

// >>> sim/serial_port_expander_16bit_tb_top.sv
// Self-checking bench for the serial port expander
`timescale 1ns/1ps
`default_nettype none
module serial_port_expander_16bit_tb_top;
  import expander_pkg::*;
  logic             i_clk;
  logic             i_nrst;
  logic             sclk, cs_n, din, dout, data_mode;
  logic [PIN_W-1:0] ext, pins_out, pins_oe, pins;
  logic [15:0]      lf, dir_m, lvl_m, rx, tx;
  int               error_cnt, tests_run, mode_m;
  // Driven bits follow the output, released ones the outside world
  assign pins = (pins_oe & pins_out) | (~pins_oe & ext);
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  serial_port_expander_16bit serial_port_expander_16bit_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_dout(dout), .i_expander_pins(pins), .o_expander_pins(pins_out),
    .o_expander_pins_oe(pins_oe), .o_data_mode(data_mode));
  link_master link_master_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
  //////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check_state();
    // Sample away from the launching edge
    @(negedge i_clk);
    chk("level", pins_out, lvl_m);
    chk("enable", pins_oe, dir_m | ~lvl_m);
    chk("mode", {15'h0000, data_mode}, mode_m[15:0]);
    chk("dout", {15'h0000, dout}, 16'h0001);
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_nrst <= 1'b0;
    dir_m = 16'h0000;
    lvl_m = 16'hffff;
    mode_m = 0;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    check_state();
  endtask
  // Short frames must leave every register untouched
  task automatic xfer(input int n);
    logic [15:0] exp;
    lf = lfsr(lf);
    tx = lfsr(lf ^ 16'h5a5a);
    @(posedge i_clk);
    ext <= lf;
    @(posedge i_clk);
    exp = lf | dir_m | ~lvl_m;
    link_master_inst.frame(tx, n, rx);
    if (n == 16) begin
      if (mode_m == 0) dir_m = tx;
      else lvl_m = tx;
      mode_m = 1;
      chk("returned", rx, exp);
    end else begin
      chk("short", rx & 16'h00ff, exp & 16'h00ff);
    end
    check_state();
  endtask
  initial begin
    i_nrst = 1'b0;
    ext = 16'h0000;
    lf = 16'h0022;
    error_cnt = 0;
    tests_run = 0;
    do_reset();
    xfer(8);
    for (int k = 0; k < 8; k++) xfer(16);
    do_reset();
    link_master_inst.hold_low();
    mode_m = 1;
    check_state();
    for (int k = 0; k < 4; k++) xfer(16);
    test_done();
  end
  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
